// file: hdl/vgc_pkg.sv
// Purpose: shared constants and carriers for the legacy graphics/attribute register block
// Assumes: byte-wide indexed I/O cycles, one system clock
// Notes: all port addresses, indexes and field positions live here
package vgc_pkg;
  // i/o port addresses
  localparam logic [15:0] GFX_INDEX_PORT = 16'h03CE;
  localparam logic [15:0] GFX_DATA_PORT = 16'h03CF;
  localparam logic [15:0] ATTR_WRITE_PORT = 16'h03C0;
  localparam logic [15:0] ATTR_READ_PORT = 16'h03C1;
  localparam logic [15:0] STATUS_MONO_PORT = 16'h03BA;
  localparam logic [15:0] STATUS_COLOR_PORT = 16'h03DA;
  // graphics register indexes
  localparam logic [7:0] IDX_MISC_GFX = 8'h06;
  localparam logic [7:0] IDX_COLOR_IGNORE = 8'h07;
  localparam logic [7:0] IDX_BIT_MASK = 8'h08;
  localparam logic [7:0] IDX_PAGING_CTRL = 8'h10;
  localparam logic [7:0] IDX_PAGE_SEL = 8'h11;
  localparam logic [7:0] IDX_SCRATCH = 8'h18;
  // writable bit masks, reserved bits read zero
  localparam logic [7:0] MISC_GFX_MASK = 8'h0F;
  localparam logic [7:0] COLOR_IGNORE_MASK = 8'h0F;
  localparam logic [7:0] PAGING_CTRL_MASK = 8'hF7;
  localparam logic [7:0] PAGE_SEL_MASK = 8'h7F;
  localparam logic [7:0] ATTR_INDEX_MASK = 8'h3F;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int MISC_GFX_MODE_BIT = 0;
  localparam int MISC_CHAIN_BIT = 1;
  localparam int MISC_MAP_LSB = 2;
  localparam int PAGING_EN_BIT = 0;
  localparam int PAGING_TGT_LSB = 1;
  localparam int ATTR_VIDEO_EN_BIT = 5;
  localparam int ATTR_MODE_GFX_BIT = 0;
  // memory map codes
  localparam logic [1:0] MAP_FULL = 2'h0;
  localparam logic [1:0] MAP_A_ONLY = 2'h1;
  localparam logic [1:0] MAP_B0 = 2'h2;
  localparam logic [1:0] MAP_B8 = 2'h3;
  localparam logic [1:0] TGT_GFX_MEM = 2'h0;
  // aperture prefixes on cpu address bits
  localparam logic [2:0] AP_FULL_TOP = 3'h5;
  localparam logic [3:0] AP_A_TOP = 4'hA;
  localparam logic [4:0] AP_B0_TOP = 5'h16;
  localparam logic [4:0] AP_B8_TOP = 5'h17;
  // attribute controller
  localparam int ATTR_DEPTH = 21;
  localparam logic [4:0] ATTR_LAST_PALETTE = 5'h0F;
  localparam logic [4:0] ATTR_MODE_IDX = 5'h10;
  localparam logic [7:0] DISP_BLANK = 8'h00;

  typedef enum logic [0:0] {ATTR_AT_INDEX = 1'b0, ATTR_AT_DATA = 1'b1} vgc_attr_ff_t;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } vgc_io_req_t;

  typedef struct packed {
    logic valid;
    logic [19:0] addr;
  } vgc_mem_req_t;
endpackage : vgc_pkg

// file: hdl/vgc_attr_mem.sv
// Purpose: storage for the attribute controller registers
// Assumes: one write port, one read port, read data registered
// Notes: read address is sampled every cycle
`timescale 1ns/10ps
`default_nettype none
module vgc_attr_mem #(
  parameter int DEPTH = 21,
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (int'(raddr) < DEPTH) begin
      rdata_d = mem[raddr];
    end
  end

  always_ff @(posedge clk) begin
    if (we && int'(waddr) < DEPTH) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end
endmodule : vgc_attr_mem
`default_nettype wire

// file: hdl/vgc_regs.sv
// Purpose: graphics misc/mask/paging registers and attribute index/data port
// Assumes: one-cycle i/o strobes synchronous to CLK, answers one cycle later to every read except status reads
// Notes: attribute storage is not reset
`timescale 1ns/10ps
`default_nettype none
module vgc_regs #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // i/o port
  input wire vgc_pkg::vgc_io_req_t IO_REQ,
  output logic [7:0] IO_RDATA,
  output logic IO_ACK,
  // system enables
  input wire logic PCI_MEM_EN,
  input wire logic MISC_MEM_EN,
  input wire logic MISC_COLOR,
  // aperture cycles
  input wire vgc_pkg::vgc_mem_req_t MEM_REQ,
  input wire logic [ADDR_W-1:0] STOLEN_BASE,
  output logic MEM_HIT,
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic MEM_PLANE_ODD,
  // read compare and write merge
  input wire logic READ_MODE1,
  input wire logic [3:0] COLOR_COMPARE,
  input wire logic [31:0] PLANE_DATA,
  input wire logic [31:0] LATCH,
  input wire logic [31:0] WR_SRC,
  output logic [7:0] CMP_RESULT,
  output logic [31:0] WR_DATA,
  // display path
  input wire logic [7:0] DISP_PIX,
  output logic [7:0] DISP_OUT,
  output logic GFX_MODE,
  output logic ATTR_GFX_MODE
);
  import vgc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // i/o decode
  logic gfx_idx_wr, gfx_dat_wr, gfx_dat_rd, gfx_idx_rd;
  logic attr_wr, attr_idx_rd, attr_dat_rd, status_rd;
  assign gfx_idx_wr = IO_REQ.wr && IO_REQ.addr == GFX_INDEX_PORT;
  assign gfx_idx_rd = IO_REQ.rd && IO_REQ.addr == GFX_INDEX_PORT;
  assign gfx_dat_wr = IO_REQ.wr && IO_REQ.addr == GFX_DATA_PORT;
  assign gfx_dat_rd = IO_REQ.rd && IO_REQ.addr == GFX_DATA_PORT;
  assign attr_wr = IO_REQ.wr && IO_REQ.addr == ATTR_WRITE_PORT;
  assign attr_idx_rd = IO_REQ.rd && IO_REQ.addr == ATTR_WRITE_PORT;
  assign attr_dat_rd = IO_REQ.rd && IO_REQ.addr == ATTR_READ_PORT;
  assign status_rd = IO_REQ.rd &&
    IO_REQ.addr == (MISC_COLOR ? STATUS_COLOR_PORT : STATUS_MONO_PORT);

  ////////////////////////////////////////////////////////////////////////////////
  // graphics registers
  logic [7:0] gidx_q, gidx_d, misc_q, misc_d, ign_q, ign_d, mask_q, mask_d;
  logic [7:0] pgc_q, pgc_d, pgs_q, pgs_d, scr_q, scr_d;

  always_comb begin
    gidx_d = gidx_q;
    misc_d = misc_q;
    ign_d = ign_q;
    mask_d = mask_q;
    pgc_d = pgc_q;
    pgs_d = pgs_q;
    scr_d = scr_q;
    if (gfx_idx_wr) begin
      gidx_d = IO_REQ.wdata;
    end
    if (gfx_dat_wr) begin
      unique case (gidx_q)
        IDX_MISC_GFX: misc_d = IO_REQ.wdata & MISC_GFX_MASK;
        IDX_COLOR_IGNORE: ign_d = IO_REQ.wdata & COLOR_IGNORE_MASK;
        IDX_BIT_MASK: mask_d = IO_REQ.wdata;
        IDX_PAGING_CTRL: pgc_d = IO_REQ.wdata & PAGING_CTRL_MASK;
        IDX_PAGE_SEL: pgs_d = IO_REQ.wdata & PAGE_SEL_MASK;
        IDX_SCRATCH: scr_d = IO_REQ.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gidx_q <= REG_RESET;
      misc_q <= REG_RESET;
      ign_q <= REG_RESET;
      mask_q <= REG_RESET;
      pgc_q <= REG_RESET;
      pgs_q <= REG_RESET;
      scr_q <= REG_RESET;
    end else begin
      gidx_q <= gidx_d;
      misc_q <= misc_d;
      ign_q <= ign_d;
      mask_q <= mask_d;
      pgc_q <= pgc_d;
      pgs_q <= pgs_d;
      scr_q <= scr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // attribute index/data flip-flop
  vgc_attr_ff_t aff_q, aff_d;
  logic [7:0] aidx_q, aidx_d;
  logic amode_q, amode_d;
  logic [4:0] aslot;
  logic video_en, pal_slot, attr_we;
  logic [7:0] attr_rdata;
  assign aslot = aidx_q[4:0];
  assign video_en = aidx_q[ATTR_VIDEO_EN_BIT];
  assign pal_slot = aslot <= ATTR_LAST_PALETTE;
  assign attr_we = attr_wr && aff_q == ATTR_AT_DATA && !(video_en && pal_slot);

  always_comb begin
    aff_d = aff_q;
    aidx_d = aidx_q;
    amode_d = amode_q;
    if (attr_wr) begin
      unique case (aff_q)
        ATTR_AT_INDEX: begin
          aidx_d = IO_REQ.wdata & ATTR_INDEX_MASK;
          aff_d = ATTR_AT_DATA;
        end
        ATTR_AT_DATA: begin
          aff_d = ATTR_AT_INDEX;
          if (aslot == ATTR_MODE_IDX) begin
            amode_d = IO_REQ.wdata[ATTR_MODE_GFX_BIT];
          end
        end
      endcase
    end
    if (status_rd) begin
      aff_d = ATTR_AT_INDEX;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aff_q <= ATTR_AT_INDEX;
      aidx_q <= REG_RESET;
      amode_q <= 1'b0;
    end else begin
      aff_q <= aff_d;
      aidx_q <= aidx_d;
      amode_q <= amode_d;
    end
  end

  vgc_attr_mem #(.DEPTH(ATTR_DEPTH), .AW(5), .DW(8)) u_attr_mem (
    .clk(CLK),
    .arst_n(ARST_N),
    .we(attr_we),
    .waddr(aslot),
    .wdata(IO_REQ.wdata),
    .raddr(aslot),
    .rdata_q(attr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read-back
  logic [7:0] rdata_q, rdata_d;
  logic ack_q, ack_d;

  always_comb begin
    rdata_d = rdata_q;
    ack_d = gfx_idx_rd || gfx_dat_rd || attr_idx_rd || attr_dat_rd;
    if (gfx_idx_rd) begin
      rdata_d = gidx_q;
    end else if (attr_idx_rd) begin
      rdata_d = aidx_q;
    end else if (attr_dat_rd) begin
      rdata_d = (video_en && pal_slot) ? REG_RESET : attr_rdata;
    end else if (gfx_dat_rd) begin
      unique case (gidx_q)
        IDX_MISC_GFX: rdata_d = misc_q;
        IDX_COLOR_IGNORE: rdata_d = ign_q;
        IDX_BIT_MASK: rdata_d = mask_q;
        IDX_PAGING_CTRL: rdata_d = pgc_q;
        IDX_PAGE_SEL: rdata_d = pgs_q;
        IDX_SCRATCH: rdata_d = scr_q;
        default: rdata_d = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= REG_RESET;
      ack_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end
  assign IO_RDATA = rdata_q;
  assign IO_ACK = ack_q;

  ////////////////////////////////////////////////////////////////////////////////
  // aperture decode and address forming
  logic [1:0] map_mode, pg_tgt;
  logic map_hit, pg_en, chain;
  logic [15:0] off;
  logic hit_q, hit_d, odd_q, odd_d;
  logic [ADDR_W-1:0] maddr_q, maddr_d;
  assign map_mode = misc_q[MISC_MAP_LSB +: 2];
  assign chain = misc_q[MISC_CHAIN_BIT];
  assign pg_en = pgc_q[PAGING_EN_BIT];
  assign pg_tgt = pgc_q[PAGING_TGT_LSB +: 2];
  assign off = MEM_REQ.addr[15:0];

  always_comb begin
    unique case (map_mode)
      MAP_FULL: map_hit = MEM_REQ.addr[19:17] == AP_FULL_TOP;
      MAP_A_ONLY: map_hit = MEM_REQ.addr[19:16] == AP_A_TOP;
      MAP_B0: map_hit = MEM_REQ.addr[19:15] == AP_B0_TOP;
      MAP_B8: map_hit = MEM_REQ.addr[19:15] == AP_B8_TOP;
    endcase
  end

  always_comb begin
    hit_d = MEM_REQ.valid && map_hit && PCI_MEM_EN && MISC_MEM_EN;
    odd_d = 1'b0;
    if (pg_en) begin
      hit_d = hit_d && pg_tgt == TGT_GFX_MEM;
      maddr_d = STOLEN_BASE + ADDR_W'({pgs_q[6:0], off[15:2], 2'b00});
    end else if (chain) begin
      odd_d = off[0];
      maddr_d = STOLEN_BASE + ADDR_W'({off[0], off[14:1], off[15]});
    end else begin
      maddr_d = STOLEN_BASE + ADDR_W'(off);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hit_q <= 1'b0;
      odd_q <= 1'b0;
      maddr_q <= '0;
    end else begin
      hit_q <= hit_d;
      odd_q <= odd_d;
      maddr_q <= maddr_d;
    end
  end
  assign MEM_HIT = hit_q;
  assign MEM_ADDR = maddr_q;
  assign MEM_PLANE_ODD = odd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // color compare, bit-mask merge, display blanking
  logic [7:0] cmp_q, cmp_d, disp_q, disp_d;
  logic [31:0] wr_q, wr_d;
  logic gfx_q, agfx_q;

  for (genvar b = 0; b < 8; b++) begin : g_bit
    logic [3:0] match;
    for (genvar p = 0; p < 4; p++) begin : g_plane
      assign match[p] = !ign_q[p] || PLANE_DATA[p*8+b] == COLOR_COMPARE[p];
      assign wr_d[p*8+b] = mask_q[b] ? WR_SRC[p*8+b] : LATCH[p*8+b];
    end
    assign cmp_d[b] = READ_MODE1 && (&match);
  end

  assign disp_d = video_en ? DISP_PIX : DISP_BLANK;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmp_q <= REG_RESET;
      wr_q <= '0;
      disp_q <= DISP_BLANK;
      gfx_q <= 1'b0;
      agfx_q <= 1'b0;
    end else begin
      cmp_q <= cmp_d;
      wr_q <= wr_d;
      disp_q <= disp_d;
      gfx_q <= misc_d[MISC_GFX_MODE_BIT];
      agfx_q <= amode_d;
    end
  end
  assign CMP_RESULT = cmp_q;
  assign WR_DATA = wr_q;
  assign DISP_OUT = disp_q;
  assign GFX_MODE = gfx_q;
  assign ATTR_GFX_MODE = agfx_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_map_gate;
    @(posedge CLK) disable iff (!ARST_N)
      MEM_REQ.valid && !(PCI_MEM_EN && MISC_MEM_EN) |=> !MEM_HIT;
  endproperty
  a_map_gate: assert property (p_map_gate) else $error("aperture hit without enables");

  property p_map_a_only;
    @(posedge CLK) disable iff (!ARST_N)
      map_mode == MAP_A_ONLY && MEM_REQ.addr[19:16] != AP_A_TOP |=> !MEM_HIT;
  endproperty
  a_map_a_only: assert property (p_map_a_only) else $error("hit outside A window");

  property p_page_addr;
    @(posedge CLK) disable iff (!ARST_N)
      pg_en |=> MEM_ADDR[22:16] == $past(pgs_q[6:0]) + $past(STOLEN_BASE[22:16])
        || $past(STOLEN_BASE[15:0]) != 16'h0000;
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("page bits not in address");

  property p_toggle;
    @(posedge CLK) disable iff (!ARST_N)
      attr_wr && !status_rd |=> aff_q != $past(aff_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("attribute flip-flop did not toggle");

  property p_status;
    @(posedge CLK) disable iff (!ARST_N)
      status_rd |=> aff_q == ATTR_AT_INDEX;
  endproperty
  a_status: assert property (p_status) else $error("status read left flip-flop at data");

  property p_data_rd;
    @(posedge CLK) disable iff (!ARST_N)
      attr_dat_rd && !attr_wr && !status_rd |=> $stable(aff_q) ##1 IO_RDATA == $past(rdata_q);
  endproperty
  a_data_rd: assert property (p_data_rd) else $error("data read moved flip-flop");

  property p_blank;
    @(posedge CLK) disable iff (!ARST_N)
      !video_en ##1 !video_en |-> DISP_OUT == DISP_BLANK;
  endproperty
  a_blank: assert property (p_blank) else $error("display not blanked");

  property p_mask;
    @(posedge CLK) disable iff (!ARST_N)
      mask_q == REG_RESET |=> WR_DATA == $past(LATCH);
  endproperty
  a_mask: assert property (p_mask) else $error("masked bits not from latch");

  property p_cmp_mode;
    @(posedge CLK) disable iff (!ARST_N)
      !READ_MODE1 |=> CMP_RESULT == REG_RESET;
  endproperty
  a_cmp_mode: assert property (p_cmp_mode) else $error("compare outside read mode 1");

  property p_reserved;
    @(posedge CLK) disable iff (!ARST_N)
      gfx_dat_wr && gidx_q == IDX_PAGE_SEL |=> pgs_q[7] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit stored");
endmodule : vgc_regs
`default_nettype wire

// file: test/vgc_host.sv
// Purpose: host cpu model issuing i/o and aperture cycles
// Assumes: requests launched just after a rising edge, one at a time
// Notes: answers are polled for a bounded number of cycles
`timescale 1ns/10ps
`default_nettype none
module vgc_host (
  // clock
  input wire logic clk,
  // requests
  output var vgc_pkg::vgc_io_req_t io_req,
  output var vgc_pkg::vgc_mem_req_t mem_req,
  // answers
  input wire logic io_ack,
  input wire logic [7:0] io_rdata,
  input wire logic mem_hit,
  input wire logic [31:0] mem_addr,
  input wire logic mem_odd
);
  import vgc_pkg::*;
  initial begin
    io_req = '0;
    mem_req = '0;
  end
  ////////////////////////////////////////////////////////////
  // paging registers are only ever reached through these i/o cycles
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    io_req.wr <= 1'b0;
  endtask : io_wr
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic ack);
    ack = 1'b0;
    d = 8'h00;
    @(posedge clk);
    io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    io_req.rd <= 1'b0;
    repeat (3) begin
      #1;
      if (io_ack === 1'b1 && ack === 1'b0) begin
        ack = 1'b1;
        d = io_rdata;
      end
      @(posedge clk);
    end
  endtask : io_rd
  task automatic mem_cyc(input logic [19:0] a, output logic hit, output logic [31:0] ad,
    output logic odd);
    hit = 1'b0;
    ad = '0;
    odd = 1'b0;
    @(posedge clk);
    mem_req <= '{valid: 1'b1, addr: a};
    @(posedge clk);
    mem_req.valid <= 1'b0;
    repeat (3) begin
      #1;
      if (mem_hit === 1'b1 && hit === 1'b0) begin
        hit = 1'b1;
        ad = mem_addr;
        odd = mem_odd;
      end
      @(posedge clk);
    end
  endtask : mem_cyc
endmodule : vgc_host
`default_nettype wire

// file: test/vgc_regs_tb.sv
// Purpose: self-checking bench for the graphics/attribute register block
// Assumes: host model drives i/o and aperture cycles
// Notes: seed fixed at 38
`timescale 1ns/10ps
`default_nettype none
module vgc_regs_tb;
  import vgc_pkg::*;
  logic clk, arst_n, pci_mem_en, misc_mem_en, misc_color, read_mode1;
  vgc_io_req_t io_req;
  vgc_mem_req_t mem_req;
  logic [7:0] io_rdata, cmp_result, disp_pix, disp_out, rd, dv, mv;
  logic io_ack, mem_hit, mem_odd, gfx_mode, attr_gfx_mode, ack, hit, odd;
  logic [31:0] stolen_base, mem_addr, plane_data, latch, wr_src, wr_data, ad, ex;
  logic [3:0] color_compare;
  logic [19:0] a;
  int miscompares, tests_run, seed;
  logic [7:0] idx_tab [6] = '{8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h18};
  logic [7:0] msk_tab [6] = '{8'h0F, 8'h0F, 8'hFF, 8'hF7, 8'h7F, 8'hFF};
  logic [19:0] ap_tab [4] = '{20'hA0000, 20'hB0000, 20'hB8000, 20'hC0000};

  always #10 clk = ~clk;

  vgc_regs vgc_regs_inst (.CLK(clk), .ARST_N(arst_n), .IO_REQ(io_req), .IO_RDATA(io_rdata),
    .IO_ACK(io_ack), .PCI_MEM_EN(pci_mem_en), .MISC_MEM_EN(misc_mem_en),
    .MISC_COLOR(misc_color),
    .MEM_REQ(mem_req), .STOLEN_BASE(stolen_base), .MEM_HIT(mem_hit), .MEM_ADDR(mem_addr),
    .MEM_PLANE_ODD(mem_odd), .READ_MODE1(read_mode1), .COLOR_COMPARE(color_compare),
    .PLANE_DATA(plane_data), .LATCH(latch), .WR_SRC(wr_src), .CMP_RESULT(cmp_result),
    .WR_DATA(wr_data), .DISP_PIX(disp_pix), .DISP_OUT(disp_out), .GFX_MODE(gfx_mode),
    .ATTR_GFX_MODE(attr_gfx_mode));
  vgc_host vgc_host_inst (.clk(clk), .io_req(io_req), .mem_req(mem_req), .io_ack(io_ack),
    .io_rdata(io_rdata), .mem_hit(mem_hit), .mem_addr(mem_addr), .mem_odd(mem_odd));

  ////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic gwr(logic [7:0] idx, logic [7:0] d);
    vgc_host_inst.io_wr(GFX_INDEX_PORT, idx);
    vgc_host_inst.io_wr(GFX_DATA_PORT, d);
  endtask : gwr
  task automatic grd(logic [7:0] idx);
    vgc_host_inst.io_wr(GFX_INDEX_PORT, idx);
    vgc_host_inst.io_rd(GFX_DATA_PORT, rd, ack);
    check("read ack", ack, 1'b1);
  endtask : grd
  task automatic aw(logic [7:0] d);
    vgc_host_inst.io_wr(ATTR_WRITE_PORT, d);
  endtask : aw
  task automatic ar(logic [15:0] p, logic [7:0] exp);
    vgc_host_inst.io_rd(p, rd, ack);
    check("attr read", rd, exp);
  endtask : ar
  task automatic disp(logic on);
    @(posedge clk);
    disp_pix <= 8'($random(seed)) | 8'h01;
    @(posedge clk);
    #1;
    check("display", disp_out, on ? disp_pix : 8'h00);
  endtask : disp
  function automatic logic map_hit(logic [1:0] c, logic [19:0] ap);
    case (c)
      2'h0: return ap[19:17] == 3'h5;
      2'h1: return ap[19:16] == 4'hA;
      2'h2: return ap[19:15] == 5'h16;
      default: return ap[19:15] == 5'h17;
    endcase
  endfunction : map_hit
  function automatic logic [7:0] exp_cmp(logic [3:0] ign, logic [3:0] cc, logic [31:0] pd);
    logic [7:0] r;
    r = 8'hFF;
    for (int p = 0; p < 4; p++) begin
      if (ign[p]) r = r & ~(pd[p*8 +: 8] ^ {8{cc[p]}});
    end
    return r;
  endfunction : exp_cmp
  function automatic logic [31:0] exp_merge(logic [7:0] m, logic [31:0] l, logic [31:0] s);
    logic [31:0] r;
    for (int p = 0; p < 4; p++) begin
      r[p*8 +: 8] = (s[p*8 +: 8] & m) | (l[p*8 +: 8] & ~m);
    end
    return r;
  endfunction : exp_merge

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    seed = 38;
    clk = 1'b0;
    arst_n = 1'b0;
    {pci_mem_en, misc_mem_en, misc_color, read_mode1} = 4'h0;
    {color_compare, plane_data, latch, wr_src, disp_pix} = '0;
    stolen_base = 32'($random(seed)) & 32'hFF800000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      grd(idx_tab[i]);
      check("reset value", rd, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      dv = 8'($random(seed)) | 8'h81;
      gwr(idx_tab[i], dv);
      grd(idx_tab[i]);
      check("reg readback", rd, dv & msk_tab[i]);
      if (i == 0) check("gfx mode", gfx_mode, dv[0]);
    end
    gwr(8'h09, 8'hFF);
    grd(8'h09);
    check("unmapped read", rd, 8'h00);
    gwr(IDX_PAGING_CTRL, 8'h00);
    for (int e = 0; e < 4; e++) begin
      for (int c = 0; c < 4; c++) begin
        gwr(IDX_MISC_GFX, {4'h0, c[1:0], 2'b10});
        for (int k = 0; k < 4; k++) begin
          @(posedge clk);
          pci_mem_en <= e[0];
          misc_mem_en <= e[1];
          a = ap_tab[k] | (20'($random(seed)) & 20'h07FFF);
          vgc_host_inst.mem_cyc(a, hit, ad, odd);
          check("aperture hit", hit, (e == 3) && map_hit(c[1:0], a));
          if (hit === 1'b1) check("odd plane", odd, a[0]);
          ex = stolen_base + {16'h0000, a[0], a[14:1], a[15]};
          if (hit === 1'b1) check("chain addr", ad, ex);
        end
      end
    end
    gwr(IDX_MISC_GFX, 8'h06);
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 4; k++) begin
        dv = 8'($random(seed));
        gwr(IDX_PAGE_SEL, dv);
        gwr(IDX_PAGING_CTRL, {4'hF, 1'b0, t[1:0], 1'b1});
        a = 20'hA0000 | (20'($random(seed)) & 20'h0FFFF);
        vgc_host_inst.mem_cyc(a, hit, ad, odd);
        check("paged hit", hit, t == 0);
        ex = stolen_base + {9'h000, dv[6:0], a[15:2], 2'b00};
        if (t == 0) check("paged addr", ad, ex);
      end
    end
    gwr(IDX_PAGING_CTRL, 8'h00);
    for (int k = 0; k < 24; k++) begin
      if (k % 8 == 0) begin
        dv = (k == 0) ? 8'h00 : 8'($random(seed));
        gwr(IDX_COLOR_IGNORE, dv);
        mv = (k == 8) ? 8'h00 : (k == 16) ? 8'hFF : 8'($random(seed));
        gwr(IDX_BIT_MASK, mv);
      end
      @(posedge clk);
      read_mode1 <= k[0];
      color_compare <= 4'($random(seed));
      plane_data <= $random(seed);
      latch <= $random(seed);
      wr_src <= $random(seed);
      @(posedge clk);
      #1;
      ex = read_mode1 ? {24'h0, exp_cmp(dv[3:0], color_compare, plane_data)} : 32'h0;
      check("compare", cmp_result, ex);
      check("merge", wr_data, exp_merge(mv, latch, wr_src));
    end
    @(posedge clk);
    misc_color <= 1'b1;
    vgc_host_inst.io_rd(STATUS_COLOR_PORT, rd, ack);
    check("status ack", ack, 1'b0);
    aw(8'h05);
    aw(8'h3C);
    aw(8'h10);
    aw(8'h01);
    disp(1'b0);
    check("attr mode", attr_gfx_mode, 1'b1);
    aw(8'h05);
    ar(ATTR_READ_PORT, 8'h3C);
    ar(ATTR_READ_PORT, 8'h3C);
    aw(8'h14);
    ar(ATTR_WRITE_PORT, 8'h05);
    ar(ATTR_READ_PORT, 8'h14);
    aw(8'h0A);
    vgc_host_inst.io_rd(STATUS_MONO_PORT, rd, ack);
    aw(8'h0A);
    ar(ATTR_READ_PORT, 8'h0A);
    aw(8'h07);
    vgc_host_inst.io_rd(STATUS_COLOR_PORT, rd, ack);
    aw(8'h25);
    ar(ATTR_WRITE_PORT, 8'h25);
    ar(ATTR_READ_PORT, 8'h00);
    disp(1'b1);
    aw(8'h77);
    aw(8'h05);
    ar(ATTR_READ_PORT, 8'h14);
    disp(1'b0);
    conclude();
  end
endmodule : vgc_regs_tb
`default_nettype wire
